// File: shared/grs_pkg.sv
package grs_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_LIST = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_OP = 8'h1c;
  // status word bit positions
  localparam int ST_DMA = 0;
  localparam int ST_TA = 1;
  localparam int ST_LA = 2;
  localparam int ST_DET = 4;
  localparam int ST_CIC = 7;
  localparam int ST_BUSY = 16;
  localparam int ST_REFUSED = 17;
  // ctrl bits
  localparam int CTRL_SYSCTL = 0;
  localparam int CMD_START = 0;
  // interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSE = 1;
  localparam int IRQ_TRIG = 2;
  localparam int IRQ_W = 3;
  // device list
  localparam int LIST_MAX = 15;
  localparam int ADDR_W = 5;
  // list entry layout: bit 5 = no secondary, bit 13 = end marker
  localparam int ENT_PRI_LSB = 0;
  localparam int ENT_NOSEC = 5;
  localparam int ENT_SEC_LSB = 8;
  localparam int ENT_END = 13;
  // bus command byte prefixes
  localparam logic [7:0] MLA_BASE = 8'h20;
  localparam logic [7:0] MSA_BASE = 8'h60;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  typedef enum logic [2:0] {
    GRS_IDLE = 3'b000,
    GRS_REN = 3'b001,
    GRS_UNL = 3'b010,
    GRS_PRI = 3'b011,
    GRS_SEC = 3'b100,
    GRS_NEXT = 3'b101
  } grs_state_t;
endpackage : grs_pkg

// File: core/grs_irq.sv
`timescale 1ns/1ps
module grs_irq #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] evt,
  input wire logic [W-1:0] clr,
  input wire logic en_wr,
  input wire logic [W-1:0] en_wdata,
  output logic [W-1:0] stat_q,
  output logic [W-1:0] en_q,
  output logic irq
);
  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= (stat_q & ~clr) | evt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= '0;
    end else if (ce && en_wr) begin
      en_q <= en_wdata;
    end
  end

  assign irq = |(stat_q & en_q);
endmodule : grs_irq

// File: core/grs_top.sv
`timescale 1ns/1ps
// Contract
// - listener_addressed_flag is set while the board is addressed to listen.
// - talker_addressed_flag is set while the board is addressed to talk.
// - the transfer-active flag reads set while a dma transfer is in progress.
// - remote_enable_operation runs only as system controller and is refused otherwise.
// - an empty device list only asserts ren and addresses nobody.
// - a non-empty list asserts ren, then addresses every listed device to listen.
// - the device list holds 0 to 15 primary/secondary address pairs.
// - controller_in_charge_flag is set while the board is active controller.
// - triggered_flag is set once a bus trigger addressed to the board arrives.
module grs_top #(
  parameter int LIST_N = grs_pkg::LIST_MAX
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic listen_addressed,
  input wire logic talk_addressed,
  input wire logic dma_active,
  input wire logic active_controller,
  input wire logic trigger_rx,
  output logic ren_q,
  output logic [7:0] cmd_byte_q,
  output logic cmd_valid_q,
  input wire logic cmd_ready,
  output logic irq
);
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && penable && !pwrite && ce;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      grs_pkg::ADDR_STATUS, grs_pkg::ADDR_CTRL, grs_pkg::ADDR_LIST, grs_pkg::ADDR_CMD,
      grs_pkg::ADDR_IRQ_STAT, grs_pkg::ADDR_IRQ_EN, grs_pkg::ADDR_IRQ_CLR, grs_pkg::ADDR_OP: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // ------------------------------------------------------------
  // control and device list
  // ------------------------------------------------------------
  logic sysctl_q;
  logic [13:0] list_q [LIST_N];
  logic [3:0] list_idx_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysctl_q <= 1'b0;
    end else if (wr_en && paddr == grs_pkg::ADDR_CTRL) begin
      sysctl_q <= pwdata[grs_pkg::CTRL_SYSCTL];
    end
  end

  // list write port: bits 19:16 select the entry, up to 15 pairs
  always_ff @(posedge clk) begin
    if (wr_en && paddr == grs_pkg::ADDR_LIST && int'(pwdata[19:16]) < LIST_N) begin
      list_q[pwdata[19:16]] <= pwdata[13:0];
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  logic triggered_flag_q;
  logic trig_clr;
  assign trig_clr = rd_en && paddr == grs_pkg::ADDR_STATUS;
  // cleared by reading status; a trigger in that cycle still wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      triggered_flag_q <= 1'b0;
    end else if (ce) begin
      triggered_flag_q <= trigger_rx | (triggered_flag_q & ~trig_clr);
    end
  end

  // ------------------------------------------------------------
  // remote enable sequencer
  // ------------------------------------------------------------
  grs_pkg::grs_state_t st_q;
  logic refused_q;
  logic start;
  logic [13:0] ent;
  logic done_evt;
  logic refuse_evt;
  assign start = wr_en && paddr == grs_pkg::ADDR_CMD && pwdata[grs_pkg::CMD_START];
  assign ent = list_q[list_idx_q];

  function automatic logic list_end(input logic [13:0] e, input logic [3:0] idx);
    list_end = e[grs_pkg::ENT_END] || int'(idx) >= LIST_N;
  endfunction : list_end

  assign refuse_evt = start && (st_q == grs_pkg::GRS_IDLE) && !sysctl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else if (ce && start && st_q == grs_pkg::GRS_IDLE) begin
      refused_q <= !sysctl_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ren_q <= 1'b0;
    end else if (ce && st_q == grs_pkg::GRS_REN) begin
      ren_q <= 1'b1;
    end
  end

  // ren asserted first; bus devices go remote only when addressed next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= grs_pkg::GRS_IDLE;
      list_idx_q <= '0;
      cmd_byte_q <= '0;
      cmd_valid_q <= 1'b0;
    end else if (ce) begin
      if (cmd_valid_q && cmd_ready) begin
        cmd_valid_q <= 1'b0;
      end
      case (st_q)
        grs_pkg::GRS_IDLE: begin
          if (start && sysctl_q) begin
            st_q <= grs_pkg::GRS_REN;
            list_idx_q <= '0;
          end
        end
        grs_pkg::GRS_REN: begin
          // empty list: ren only, nothing addressed
          st_q <= list_end(ent, list_idx_q) ? grs_pkg::GRS_IDLE : grs_pkg::GRS_UNL;
        end
        grs_pkg::GRS_UNL: begin
          if (!cmd_valid_q || cmd_ready) begin
            cmd_byte_q <= grs_pkg::CMD_UNL;
            cmd_valid_q <= 1'b1;
            st_q <= grs_pkg::GRS_PRI;
          end
        end
        grs_pkg::GRS_PRI: begin
          if (!cmd_valid_q || cmd_ready) begin
            cmd_byte_q <= grs_pkg::MLA_BASE | 8'(ent[grs_pkg::ENT_PRI_LSB +: grs_pkg::ADDR_W]);
            cmd_valid_q <= 1'b1;
            st_q <= ent[grs_pkg::ENT_NOSEC] ? grs_pkg::GRS_NEXT : grs_pkg::GRS_SEC;
          end
        end
        grs_pkg::GRS_SEC: begin
          if (!cmd_valid_q || cmd_ready) begin
            cmd_byte_q <= grs_pkg::MSA_BASE | 8'(ent[grs_pkg::ENT_SEC_LSB +: grs_pkg::ADDR_W]);
            cmd_valid_q <= 1'b1;
            st_q <= grs_pkg::GRS_NEXT;
          end
        end
        grs_pkg::GRS_NEXT: begin
          // walk on until the end marker or the 15th pair
          if (!cmd_valid_q || cmd_ready) begin
            if (list_end(list_q[list_idx_q + 4'h1], list_idx_q + 4'h1)) begin
              st_q <= grs_pkg::GRS_IDLE;
            end else begin
              list_idx_q <= list_idx_q + 4'h1;
              st_q <= grs_pkg::GRS_PRI;
            end
          end
        end
        default: st_q <= grs_pkg::GRS_IDLE;
      endcase
    end
  end

  assign done_evt = ce && st_q != grs_pkg::GRS_IDLE && st_q != grs_pkg::GRS_UNL &&
    ((st_q == grs_pkg::GRS_REN && list_end(ent, list_idx_q)) ||
     (st_q == grs_pkg::GRS_NEXT && (!cmd_valid_q || cmd_ready) &&
      list_end(list_q[list_idx_q + 4'h1], list_idx_q + 4'h1)));

  // op register is read-only: ren holds until reset so a later lockout keeps devices remote

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic [grs_pkg::IRQ_W-1:0] evt;
  logic [grs_pkg::IRQ_W-1:0] irq_stat;
  logic [grs_pkg::IRQ_W-1:0] irq_en;
  logic [grs_pkg::IRQ_W-1:0] irq_clr;
  assign evt = {trigger_rx, refuse_evt, done_evt};
  assign irq_clr = (wr_en && paddr == grs_pkg::ADDR_IRQ_CLR) ? pwdata[grs_pkg::IRQ_W-1:0] : '0;

  grs_irq #(.W(grs_pkg::IRQ_W)) u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .evt(evt),
    .clr(irq_clr),
    .en_wr(wr_en && paddr == grs_pkg::ADDR_IRQ_EN),
    .en_wdata(pwdata[grs_pkg::IRQ_W-1:0]),
    .stat_q(irq_stat),
    .en_q(irq_en),
    .irq(irq)
  );

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[grs_pkg::ST_DMA] = dma_active;
    status_word[grs_pkg::ST_TA] = talk_addressed;
    status_word[grs_pkg::ST_LA] = listen_addressed;
    status_word[grs_pkg::ST_DET] = triggered_flag_q;
    status_word[grs_pkg::ST_CIC] = active_controller;
    status_word[grs_pkg::ST_BUSY] = st_q != grs_pkg::GRS_IDLE;
    status_word[grs_pkg::ST_REFUSED] = refused_q;
  end

  always_comb begin
    case (paddr)
      grs_pkg::ADDR_STATUS: prdata = status_word;
      grs_pkg::ADDR_CTRL: prdata = {31'h0, sysctl_q};
      grs_pkg::ADDR_IRQ_STAT: prdata = {29'h0, irq_stat};
      grs_pkg::ADDR_IRQ_EN: prdata = {29'h0, irq_en};
      grs_pkg::ADDR_OP: prdata = {31'h0, ren_q};
      default: prdata = 32'h0;
    endcase
  end
endmodule : grs_top

// File: dv/grs_top_sva.sv
`timescale 1ns/1ps
// ----------
// checker
// ----------
module grs_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic listen_addressed,
  input wire logic talk_addressed,
  input wire logic dma_active,
  input wire logic active_controller,
  input wire logic ren_q,
  input wire logic [7:0] cmd_byte_q,
  input wire logic cmd_valid_q,
  input wire logic cmd_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire st_rd = psel && !pwrite && paddr == grs_pkg::ADDR_STATUS;
  sequence s_stall;
    cmd_valid_q && !cmd_ready;
  endsequence
  sequence s_held;
    cmd_valid_q && $stable(cmd_byte_q);
  endsequence
  a_la_shown: assert property (st_rd |-> prdata[grs_pkg::ST_LA] == listen_addressed)
    else $error("listen flag wrong");
  a_ta_shown: assert property (st_rd |-> prdata[grs_pkg::ST_TA] == talk_addressed)
    else $error("talk flag wrong");
  a_dma_shown: assert property (st_rd |-> prdata[grs_pkg::ST_DMA] == dma_active)
    else $error("dma flag wrong");
  a_cic_shown: assert property (st_rd |-> prdata[grs_pkg::ST_CIC] == active_controller)
    else $error("controller flag wrong");
  a_ren_sticky: assert property (ren_q |=> ren_q)
    else $error("ren dropped");
  a_ren_first: assert property (cmd_valid_q |-> ren_q)
    else $error("byte offered before ren");
  a_byte_held: assert property (s_stall |=> s_held)
    else $error("stalled byte changed");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h1c |-> pslverr && pready)
    else $error("unmapped access not refused");
endmodule : grs_sva
bind grs_top grs_sva u_sva (
  .clk(clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .listen_addressed(listen_addressed),
  .talk_addressed(talk_addressed),
  .dma_active(dma_active),
  .active_controller(active_controller),
  .ren_q(ren_q),
  .cmd_byte_q(cmd_byte_q),
  .cmd_valid_q(cmd_valid_q),
  .cmd_ready(cmd_ready)
);

// File: dv/grs_bus_model.sv
`timescale 1ns/1ps
module grs_bus_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ren,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  output logic cmd_ready
);
  logic [7:0] got[$];
  logic [31:0] remote;
  logic [1:0] cnt;
  // stalls one cycle in four so held bytes get exercised
  assign cmd_ready = cnt != 2'h3;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      remote <= 32'h0;
    end else begin
      cnt <= cnt + 2'h1;
      if (cmd_valid && cmd_ready) begin
        got.push_back(cmd_byte);
        // ren alone is not enough, a listen address is needed too
        if (ren && cmd_byte[7:5] == 3'h1 && cmd_byte != 8'h3f) remote[cmd_byte[4:0]] <= 1'b1;
      end
    end
  end
endmodule : grs_bus_model

// File: dv/gpib_remote_and_status_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module gpib_remote_and_status_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic trigger_rx = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd, prdata;
  logic [3:0] lines = 4'h0;
  logic pready, pslverr, ren_q, cmd_valid_q, cmd_ready, irq, err;
  logic [7:0] cmd_byte_q;
  logic [7:0] exp[$];
  int checks = 0;
  int miscompares = 0;
  initial forever #2 clk = ~clk;
  grs_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .listen_addressed(lines[0]),
    .talk_addressed(lines[1]), .dma_active(lines[2]), .active_controller(lines[3]), .trigger_rx(trigger_rx),
    .ren_q(ren_q), .cmd_byte_q(cmd_byte_q), .cmd_valid_q(cmd_valid_q), .cmd_ready(cmd_ready), .irq(irq));
  grs_bus_model bus (.clk(clk), .rst_n(rst_n), .ren(ren_q), .cmd_byte(cmd_byte_q), .cmd_valid(cmd_valid_q),
    .cmd_ready(cmd_ready));
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin miscompares++; wrap_up(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, grs_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[grs_pkg::ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin miscompares++; wrap_up(); end
  endtask : wait_idle
  task automatic t_status;
    for (int i = 0; i < 16; i++) begin
      lines <= i[3:0];
      @(posedge clk);
      xfer(1'b0, grs_pkg::ADDR_STATUS, 32'h0);
      `CHK("listen", lines[0], rd[grs_pkg::ST_LA])
      `CHK("talk", lines[1], rd[grs_pkg::ST_TA])
      `CHK("dma", lines[2], rd[grs_pkg::ST_DMA])
      `CHK("cic", lines[3], rd[grs_pkg::ST_CIC])
    end
    $display("test status done");
  endtask : t_status
  task automatic t_trig;
    for (int m = 1; m >= 0; m--) begin
      xfer(1'b1, grs_pkg::ADDR_IRQ_EN, {29'h0, m[0], 2'h0});
      trigger_rx <= 1'b1;
      @(posedge clk);
      trigger_rx <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("irq", m[0], irq)
      xfer(1'b0, grs_pkg::ADDR_STATUS, 32'h0);
      `CHK("triggered", 1'b1, rd[grs_pkg::ST_DET])
      xfer(1'b1, grs_pkg::ADDR_IRQ_CLR, 32'h4);
      xfer(1'b0, grs_pkg::ADDR_IRQ_STAT, 32'h0);
      `CHK("irq stat cleared", 1'b0, rd[grs_pkg::IRQ_TRIG])
    end
    xfer(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    // a trigger while the clock enable is low must leave no trace
    ce <= 1'b0;
    trigger_rx <= 1'b1;
    @(posedge clk);
    trigger_rx <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    xfer(1'b0, grs_pkg::ADDR_STATUS, 32'h0);
    `CHK("frozen trigger", 1'b0, rd[grs_pkg::ST_DET])
    $display("test trigger done");
  endtask : t_trig
  task automatic t_refuse;
    xfer(1'b1, grs_pkg::ADDR_CTRL, 32'h0);
    xfer(1'b1, grs_pkg::ADDR_CMD, 32'h1);
    wait_idle();
    `CHK("refused", 1'b1, rd[grs_pkg::ST_REFUSED])
    `CHK("ren", 1'b0, ren_q)
    `CHK("bytes", 0, bus.got.size())
    xfer(1'b0, grs_pkg::ADDR_IRQ_STAT, 32'h0);
    `CHK("refuse irq", 1'b1, rd[grs_pkg::IRQ_REFUSE])
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_remote(input int n);
    exp.delete();
    bus.got.delete();
    xfer(1'b1, grs_pkg::ADDR_CTRL, 32'h1);
    xfer(1'b1, grs_pkg::ADDR_IRQ_CLR, 32'h7);
    for (int i = 0; i < n; i++) begin
      // odd entries carry no secondary; primaries differ per call so remote bits are fresh
      xfer(1'b1, grs_pkg::ADDR_LIST, {12'h0, i[3:0], 3'h0, i[4:0], 2'h0, i[0], 5'(i + n)});
      exp.push_back(8'h20 | 8'(i + n));
      if (!i[0]) exp.push_back(8'h60 | 8'(i));
    end
    if (n < 15) xfer(1'b1, grs_pkg::ADDR_LIST, {12'h0, n[3:0], 2'h0, 1'b1, 13'h0});
    if (n > 0) exp.push_front(8'h3f);
    xfer(1'b1, grs_pkg::ADDR_CMD, 32'h1);
    wait_idle();
    `CHK("not refused", 1'b0, rd[grs_pkg::ST_REFUSED])
    `CHK("ren", 1'b1, ren_q)
    `CHK("count", exp.size(), bus.got.size())
    foreach (exp[k]) `CHK("byte", exp[k], bus.got[k])
    for (int i = 0; i < n; i++) `CHK("remote", 1'b1, bus.remote[i + n])
    if (n == 0) `CHK("none remote", 32'h0, bus.remote)
    xfer(1'b0, grs_pkg::ADDR_IRQ_STAT, 32'h0);
    `CHK("done irq", 1'b1, rd[grs_pkg::IRQ_DONE])
    // ren must still stand so the host can follow with a local lockout
    xfer(1'b0, grs_pkg::ADDR_OP, 32'h0);
    `CHK("ren held", 1'b1, rd[0])
    $display("test remote %0d done", n);
  endtask : t_remote
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_status();
    t_trig();
    t_refuse();
    t_remote(0);
    t_remote(3);
    t_remote(15);
    wrap_up();
  end
endmodule : gpib_remote_and_status_tb
